// ### hw/pllc_ctrl.sv
// pllc_ctrl: digital control of a fractional/integer-N synthesizer: divider
// settings, lock detect, autoselect, fast-lock, phase step, test and lock pins.
// assumes a same-clock register port and a phase-detector clock slower than clk/2.
`timescale 1ns/1ps
module pllc_ctrl
	import pllc_pkg::*;
#(
	parameter int ADDR_W = 5
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [31:0] rdata,
	input wire logic pfd_clk_in,
	input wire logic [4:0] pfd_skew_ns,
	input wire logic [2:0] tune_adc,
	input wire logic analog_lock,
	input wire logic outputs_gate_pin,
	input wire logic readback_load,
	input wire logic readback_shift,
	output logic [15:0] n_value,
	output logic [11:0] frac_value,
	output logic [11:0] mod_value,
	output logic frac_mode,
	output logic [4:0] fb_extra_div,
	output logic n_counter_hold,
	output logic [2:0] out_a_ratio,
	output logic [2:0] out_b_ratio,
	output logic pump_hiz,
	output logic [3:0] pump_current_code,
	output logic test_out_pin,
	output logic test_out_oe,
	output logic lock_indicator,
	output logic lock_indicator_oe,
	output logic fastlock_ground_pin,
	output logic fastlock_ground_oe,
	output logic [5:0] vco_sel,
	output logic autoselect_busy,
	output logic out_a_enable,
	output logic out_b_enable,
	output logic [11:0] phase_offset,
	output logic phase_step
);
	if (ADDR_W < 5)
		$error("ADDR_W must cover seven registers");
	typedef struct packed {
		logic [31:0] r0, r1, r2, r3, r4, r5;
		logic [11:0] mod_act;
		logic [2:0] pfd_s;
		logic [4:0] skew_a, skew_b;
		logic [2:0] adc_a, adc_b;
		logic [1:0] alock_s, gate_s;
		logic [5:0] lk_cnt;
		logic lk;
		logic [7:0] bs_cnt;
		logic [3:0] vas_cnt;
		pllc_vas_t vco_autoselect;
		logic [23:0] fl_cnt;
		logic [5:0] vco;
		logic [31:0] rb;
		logic [31:0] rdata;
		logic [15:0] n_value;
		logic [11:0] frac_value, mod_value, phase;
		logic frac_mode, n_hold, pump_hiz, tpin, toe, ld, ld_oe, fl_oe, busy;
		logic ena, enb, step;
		logic [4:0] fbdiv;
		logic [2:0] ra, rbr;
		logic [3:0] pump;
		logic [5:0] vsel;
	} pllc_state_t;
	pllc_state_t st, next_st;
	logic aligned, pfd_tick, st_tick, wr0, wr2, wr3, wr4;
	logic [ADDR_W-3:0] idx;
	logic [31:0] r6;
	logic [3:0] tsel;
	logic [4:0] thr_lock, thr_unlock;
	logic [5:0] need;
	logic [7:0] bs_div;
	logic [12:0] psum;
	logic [23:0] fl_target;
	logic adc_edge;
	// address decode and pfd edge from the synchronised clock pin
	always_comb
	begin
		aligned = addr[1:0] == 2'h0;
		idx = addr[ADDR_W-1:2];
		wr0 = wr_strobe && aligned && idx == (ADDR_W-2)'(PLLC_IDX_R0);
		wr2 = wr_strobe && aligned && idx == (ADDR_W-2)'(PLLC_IDX_R2);
		wr3 = wr_strobe && aligned && idx == (ADDR_W-2)'(PLLC_IDX_R3);
		wr4 = wr_strobe && aligned && idx == (ADDR_W-2)'(PLLC_IDX_R4);
		pfd_tick = st.pfd_s[1] && !st.pfd_s[2];
		bs_div = (st.r4[PLLC_BS_LSB +: 8] == 8'h00) ? 8'h01 : st.r4[PLLC_BS_LSB +: 8];
		st_tick = pfd_tick && (st.bs_cnt + 8'h01 >= bs_div);
		tsel = {st.r5[PLLC_TSEL_MSB_BIT], st.r2[PLLC_TSEL_LSB +: 3]};
		adc_edge = st.adc_b == 3'b000 || st.adc_b == 3'b111;
		fl_target = st.mod_act * st.r3[PLLC_FLDIV_LSB +: 12];
		psum = {1'b0, st.phase} + {1'b0, st.r1[PLLC_PHASE_LSB +: 12]};
		// lock windows follow speed and precision, locked-cycle count follows lock mode
		if (st.r2[PLLC_LOCK_SPEED_BIT])
		begin
			thr_lock = PLLC_SKEW_FAST_NS;
			thr_unlock = PLLC_SKEW_FAST_NS;
		end
		else
		begin
			thr_lock = st.r2[PLLC_LOCK_PREC_BIT] ? PLLC_SKEW_LOCK_FINE_NS : PLLC_SKEW_LOCK_WIDE_NS;
			thr_unlock = PLLC_SKEW_UNLOCK_NS;
		end
		need = st.r2[PLLC_LOCK_MODE_BIT] ? PLLC_LOCK_CYC_INT : PLLC_LOCK_CYC_FRAC;
		// read-only status word
		r6 = 32'h0;
		r6[PLLC_ADC_LSB +: 3] = st.adc_b;
		r6[PLLC_VCO_RD_LSB +: 6] = st.vsel;
		r6[PLLC_ST_LOCK_BIT] = st.lk;
		r6[PLLC_ST_BUSY_BIT] = st.vco_autoselect == PLLC_VAS_SEARCH;
		r6[PLLC_ST_FAST_BIT] = st.vco_autoselect == PLLC_VAS_FAST;
		r6[PLLC_ST_FRAC_BIT] = st.frac_mode;
	end
	// next state of the whole block
	always_comb
	begin
		next_st = st;
		next_st.step = 1'b0;
		// synchronisers: first stage read only by the second
		next_st.pfd_s = {st.pfd_s[1], st.pfd_s[0], pfd_clk_in};
		next_st.skew_a = pfd_skew_ns;
		next_st.skew_b = st.skew_a;
		next_st.adc_a = tune_adc;
		next_st.adc_b = st.adc_a;
		next_st.alock_s = {st.alock_s[0], analog_lock};
		next_st.gate_s = {st.gate_s[0], outputs_gate_pin};
		// register writes, modulus is double buffered by register 0
		if (wr_strobe && aligned)
		begin
			if (idx == (ADDR_W-2)'(PLLC_IDX_R0))
			begin
				next_st.r0 = wdata;
				next_st.mod_act = st.r1[PLLC_MOD_LSB +: 12];
			end
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R1))
				next_st.r1 = wdata;
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R2))
				next_st.r2 = wdata;
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R3))
				next_st.r3 = wdata;
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R4))
				next_st.r4 = wdata;
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R5))
				next_st.r5 = wdata;
		end
		// read data stands only in the cycle after the strobe
		next_st.rdata = 32'h0;
		if (rd_strobe && aligned)
		begin
			if (idx == (ADDR_W-2)'(PLLC_IDX_R0))
				next_st.rdata = st.r0;
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R1))
				next_st.rdata = st.r1;
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R2))
				next_st.rdata = st.r2;
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R3))
				next_st.rdata = st.r3;
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R4))
				next_st.rdata = st.r4;
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R5))
				next_st.rdata = st.r5;
			else if (idx == (ADDR_W-2)'(PLLC_IDX_R6))
				next_st.rdata = r6;
		end
		// digital lock detect, counted on pfd cycles
		if (wr2)
		begin
			next_st.lk_cnt = 6'h0;
			next_st.lk = 1'b0;
		end
		else if (pfd_tick)
		begin
			if (st.lk)
			begin
				if (st.skew_b > thr_unlock)
					next_st.lk = 1'b0;
				next_st.lk_cnt = 6'h0;
			end
			else if (st.skew_b <= thr_lock)
			begin
				next_st.lk_cnt = st.lk_cnt + 6'h01;
				if (st.lk_cnt + 6'h01 >= need)
					next_st.lk = 1'b1;
			end
			else
				next_st.lk_cnt = 6'h0;
		end
		// state-clock divider for the autoselect machine
		if (wr4 || st_tick)
			next_st.bs_cnt = 8'h0;
		else if (pfd_tick)
			next_st.bs_cnt = st.bs_cnt + 8'h01;
		// autoselect, retune and fast-lock sequencer
		case (st.vco_autoselect)
			PLLC_VAS_IDLE:
			begin
				if ((wr0 || (st.r3[PLLC_RETUNE_BIT] && adc_edge))
					&& !st.r3[PLLC_AS_OFF_BIT])
				begin
					next_st.vco_autoselect = PLLC_VAS_SEARCH;
					next_st.vas_cnt = 4'h0;
					next_st.vco = st.r3[PLLC_VCO_LSB +: 6];
				end
			end
			PLLC_VAS_SEARCH:
			begin
				if (st_tick)
				begin
					next_st.vas_cnt = st.vas_cnt + 4'h1;
					if (st.adc_b == 3'b111)
						next_st.vco = st.vco + 6'h01;
					else if (st.adc_b == 3'b000)
						next_st.vco = st.vco - 6'h01;
					if (st.vas_cnt + 4'h1 >= PLLC_VAS_PERIODS)
					begin
						next_st.fl_cnt = 24'h0;
						next_st.vco_autoselect = (st.r3[PLLC_CDM_LSB +: 2] == PLLC_CDM_FAST)
							? PLLC_VAS_FAST : PLLC_VAS_IDLE;
					end
				end
			end
			PLLC_VAS_FAST:
			begin
				if (wr3)
					next_st.fl_cnt = 24'h0;
				else if (pfd_tick)
				begin
					next_st.fl_cnt = st.fl_cnt + 24'h1;
					if (st.fl_cnt + 24'h1 >= fl_target)
						next_st.vco_autoselect = PLLC_VAS_IDLE;
				end
			end
			default:
				next_st.vco_autoselect = PLLC_VAS_IDLE;
		endcase
		// phase step relative to current phase, once locked
		if (wr3 && wdata[PLLC_CDM_LSB +: 2] == PLLC_CDM_PHASE && st.lk)
		begin
			next_st.phase = (psum >= {1'b0, st.mod_act}) ? 12'(psum - {1'b0, st.mod_act})
				: psum[11:0];
			next_st.step = 1'b1;
		end
		// readback shift register for the serial data output
		if (readback_load)
			next_st.rb = r6;
		else if (readback_shift)
			next_st.rb = {st.rb[30:0], 1'b0};
		// divider settings seen by the analog loop
		next_st.n_value = st.r0[PLLC_N_LSB +: 16];
		next_st.frac_value = st.r0[PLLC_FRAC_LSB +: 12];
		next_st.mod_value = st.mod_act;
		next_st.frac_mode = !st.r0[PLLC_INT_BIT]
			&& !(st.r0[PLLC_FRAC_LSB +: 12] == 12'h0 && st.r5[PLLC_ZFRAC_BIT]);
		next_st.n_hold = st.r2[PLLC_NHOLD_BIT];
		next_st.ra = st.r4[PLLC_OUTA_RATIO_LSB +: 3];
		next_st.rbr = st.r4[PLLC_OUTB_SRC_BIT] ? 3'h0 : st.r4[PLLC_OUTA_RATIO_LSB +: 3];
		if (st.r4[PLLC_FB_SEL_BIT])
			next_st.fbdiv = 5'h01;
		else if (st.r4[PLLC_OUTA_RATIO_LSB + 2])
			next_st.fbdiv = PLLC_FB_CAP;
		else
			next_st.fbdiv = 5'h01 << st.r4[PLLC_OUTA_RATIO_LSB +: 2];
		next_st.pump_hiz = st.r2[PLLC_PUMP_HIZ_BIT];
		next_st.pump = (st.vco_autoselect == PLLC_VAS_FAST) ? PLLC_PUMP_MAX : st.r2[PLLC_PUMP_LSB +: 4];
		next_st.fl_oe = st.vco_autoselect == PLLC_VAS_FAST;
		next_st.busy = st.vco_autoselect == PLLC_VAS_SEARCH;
		next_st.vsel = st.r3[PLLC_AS_OFF_BIT] ? st.r3[PLLC_VCO_LSB +: 6] : st.vco;
		next_st.ena = st.r4[PLLC_OUTA_ON_BIT] && st.gate_s[1];
		next_st.enb = st.r4[PLLC_OUTB_ON_BIT] && st.gate_s[1];
		// test output pin selection
		next_st.toe = 1'b1;
		next_st.tpin = 1'b0;
		case (tsel)
			PLLC_TSEL_HIGH: next_st.tpin = 1'b1;
			PLLC_TSEL_LOW: next_st.tpin = 1'b0;
			PLLC_TSEL_ALOCK: next_st.tpin = st.alock_s[1];
			PLLC_TSEL_DLOCK: next_st.tpin = st.lk;
			PLLC_TSEL_READBACK: next_st.tpin = st.rb[31];
			default: next_st.toe = 1'b0;
		endcase
		// lock indicator pin, analog source is open-drain
		next_st.ld = 1'b0;
		next_st.ld_oe = 1'b1;
		if (st.r5[PLLC_LOCK_SRC_LSB +: 2] == PLLC_LSRC_DIG)
			next_st.ld = st.lk;
		else if (st.r5[PLLC_LOCK_SRC_LSB +: 2] == PLLC_LSRC_ANA)
			next_st.ld_oe = !st.alock_s[1];
		else if (st.r5[PLLC_LOCK_SRC_LSB +: 2] == 2'h3)
			next_st.ld = 1'b1;
	end
	// state register
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
			st.r0 <= PLLC_R0_RST;
			st.r1 <= PLLC_R1_RST;
			st.r2 <= PLLC_R2_RST;
			st.r3 <= PLLC_R3_RST;
			st.r4 <= PLLC_R4_RST;
			st.r5 <= PLLC_R5_RST;
			st.vco_autoselect <= PLLC_VAS_IDLE;
			st.fbdiv <= 5'h01;
			st.ld_oe <= 1'b1;
		end
		else
			st <= next_st;
	end
	// outputs straight from the state register, fastlock_ground_pin tied low
	assign rdata = st.rdata;
	assign n_value = st.n_value;
	assign frac_value = st.frac_value;
	assign mod_value = st.mod_value;
	assign frac_mode = st.frac_mode;
	assign fb_extra_div = st.fbdiv;
	assign n_counter_hold = st.n_hold;
	assign out_a_ratio = st.ra;
	assign out_b_ratio = st.rbr;
	assign pump_hiz = st.pump_hiz;
	assign pump_current_code = st.pump;
	assign test_out_pin = st.tpin;
	assign test_out_oe = st.toe;
	assign lock_indicator = st.ld;
	assign lock_indicator_oe = st.ld_oe;
	assign fastlock_ground_pin = 1'b0;
	assign fastlock_ground_oe = st.fl_oe;
	assign vco_sel = st.vsel;
	assign autoselect_busy = st.busy;
	assign out_a_enable = st.ena;
	assign out_b_enable = st.enb;
	assign phase_offset = st.phase;
	assign phase_step = st.step;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_vas_kick;
		st.vco_autoselect == PLLC_VAS_IDLE && wr0 && !st.r3[PLLC_AS_OFF_BIT];
	endsequence
	sequence s_search_then_busy;
		st.vco_autoselect == PLLC_VAS_SEARCH ##1 autoselect_busy;
	endsequence
	a_fb_path_ratio: assert property (st.r4[PLLC_FB_SEL_BIT] |=> fb_extra_div == 5'h01)
		else $error("feedback extra divide not one with direct path");
	a_counter_hold_follow: assert property (n_counter_hold == $past(st.r2[PLLC_NHOLD_BIT]))
		else $error("counter hold does not follow its bit");
	a_pump_hiz_bit: assert property (wr2 && wdata[PLLC_PUMP_HIZ_BIT] ##1 !wr2 |=> pump_hiz)
		else $error("pump not floated after hiz bit write");
	a_fastlock_pump_max: assert property (st.vco_autoselect == PLLC_VAS_FAST |=> &pump_current_code)
		else $error("fast-lock without maximum pump code");
	a_int_lock_count: assert property ($rose(st.lk) && st.r2[PLLC_LOCK_MODE_BIT]
		|-> $past(st.lk_cnt) == PLLC_LOCK_CYC_INT - 6'h01)
		else $error("integer lock set after wrong cycle count");
	a_vas_start_write: assert property (s_vas_kick |=> s_search_then_busy)
		else $error("autoselect did not start on register 0 write");
	a_gate_outputs_off: assert property (!st.gate_s[1] |=> !out_a_enable && !out_b_enable)
		else $error("output enabled while gate pin low");
	a_readback_pin_data: assert property (tsel == PLLC_TSEL_READBACK |=> test_out_oe
		&& test_out_pin == $past(st.rb[31]))
		else $error("test pin not carrying readback data");
	a_no_retune_off: assert property (st.vco_autoselect == PLLC_VAS_IDLE && !wr0
		&& !st.r3[PLLC_RETUNE_BIT] |=> st.vco_autoselect == PLLC_VAS_IDLE)
		else $error("retune started with retune bit clear");
endmodule

// ### include/pllc_pkg.sv
// pllc_pkg: register indices, field positions, reset values, lock-detect figures
// and state codes of the synthesizer digital control block.
// assumes a 32-bit word per register, byte address = 4 x register index.
package pllc_pkg;
	// register indices, byte address is four times the index
	localparam logic [2:0] PLLC_IDX_R0 = 3'h0;
	localparam logic [2:0] PLLC_IDX_R1 = 3'h1;
	localparam logic [2:0] PLLC_IDX_R2 = 3'h2;
	localparam logic [2:0] PLLC_IDX_R3 = 3'h3;
	localparam logic [2:0] PLLC_IDX_R4 = 3'h4;
	localparam logic [2:0] PLLC_IDX_R5 = 3'h5;
	localparam logic [2:0] PLLC_IDX_R6 = 3'h6;
	// reset values of the writable registers
	localparam logic [31:0] PLLC_R0_RST = 32'h007d0000;
	localparam logic [31:0] PLLC_R1_RST = 32'h2000fff9;
	localparam logic [31:0] PLLC_R2_RST = 32'h00004042;
	localparam logic [31:0] PLLC_R3_RST = 32'h00000000;
	localparam logic [31:0] PLLC_R4_RST = 32'h00000000;
	localparam logic [31:0] PLLC_R5_RST = 32'h00000000;
	// register 0 fields
	localparam int PLLC_INT_BIT = 31;
	localparam int PLLC_N_LSB = 15;
	localparam int PLLC_FRAC_LSB = 3;
	// register 1 fields
	localparam int PLLC_PHASE_LSB = 15;
	localparam int PLLC_MOD_LSB = 3;
	// register 2 fields
	localparam int PLLC_LOCK_SPEED_BIT = 31;
	localparam int PLLC_TSEL_LSB = 26;
	localparam int PLLC_PUMP_LSB = 9;
	localparam int PLLC_LOCK_MODE_BIT = 8;
	localparam int PLLC_LOCK_PREC_BIT = 7;
	localparam int PLLC_PUMP_HIZ_BIT = 4;
	localparam int PLLC_NHOLD_BIT = 3;
	// register 3 fields
	localparam int PLLC_VCO_LSB = 26;
	localparam int PLLC_AS_OFF_BIT = 25;
	localparam int PLLC_RETUNE_BIT = 24;
	localparam int PLLC_CDM_LSB = 15;
	localparam int PLLC_FLDIV_LSB = 3;
	// register 4 fields
	localparam int PLLC_FB_SEL_BIT = 23;
	localparam int PLLC_OUTA_RATIO_LSB = 20;
	localparam int PLLC_BS_LSB = 12;
	localparam int PLLC_OUTB_SRC_BIT = 9;
	localparam int PLLC_OUTB_ON_BIT = 8;
	localparam int PLLC_OUTA_ON_BIT = 5;
	// register 5 fields
	localparam int PLLC_ZFRAC_BIT = 24;
	localparam int PLLC_LOCK_SRC_LSB = 22;
	localparam int PLLC_TSEL_MSB_BIT = 18;
	// register 6 fields
	localparam int PLLC_ADC_LSB = 20;
	localparam int PLLC_VCO_RD_LSB = 4;
	localparam int PLLC_ST_LOCK_BIT = 31;
	localparam int PLLC_ST_BUSY_BIT = 30;
	localparam int PLLC_ST_FAST_BIT = 29;
	localparam int PLLC_ST_FRAC_BIT = 28;
	// digital lock-detect skew windows in ns and locked-cycle counts
	localparam logic [4:0] PLLC_SKEW_LOCK_WIDE_NS = 5'h0a;
	localparam logic [4:0] PLLC_SKEW_LOCK_FINE_NS = 5'h06;
	localparam logic [4:0] PLLC_SKEW_UNLOCK_NS = 5'h0f;
	localparam logic [4:0] PLLC_SKEW_FAST_NS = 5'h04;
	localparam logic [5:0] PLLC_LOCK_CYC_FRAC = 6'h28;
	localparam logic [5:0] PLLC_LOCK_CYC_INT = 6'h05;
	// autoselect length in state-clock periods and feedback cap
	localparam logic [3:0] PLLC_VAS_PERIODS = 4'ha;
	localparam logic [4:0] PLLC_FB_CAP = 5'h10;
	// clock-divider mode codes, lock source codes, test output codes and maximum pump code
	localparam logic [1:0] PLLC_CDM_FAST = 2'h1;
	localparam logic [1:0] PLLC_CDM_PHASE = 2'h2;
	localparam logic [1:0] PLLC_LSRC_DIG = 2'h1;
	localparam logic [1:0] PLLC_LSRC_ANA = 2'h2;
	localparam logic [3:0] PLLC_TSEL_HIGH = 4'h1;
	localparam logic [3:0] PLLC_TSEL_LOW = 4'h2;
	localparam logic [3:0] PLLC_TSEL_ALOCK = 4'h5;
	localparam logic [3:0] PLLC_TSEL_DLOCK = 4'h6;
	localparam logic [3:0] PLLC_TSEL_READBACK = 4'hc;
	localparam logic [3:0] PLLC_PUMP_MAX = 4'hf;
	// autoselect / fast-lock sequencer states
	typedef enum logic [2:0] {
		PLLC_VAS_IDLE = 3'b001,
		PLLC_VAS_SEARCH = 3'b010,
		PLLC_VAS_FAST = 3'b100
	} pllc_vas_t;
endpackage

// ### sim/pllc_host_model.sv
// pllc_host_model: host side of the register port, one-cycle write and read strobes.
// assumes the design answers a read in the cycle after the strobe, with no wait.
`timescale 1ns/1ps
module pllc_host_model
(
	input wire logic clk,
	input wire logic [31:0] rdata,
	output logic [4:0] addr,
	output logic [31:0] wdata,
	output logic wr_strobe,
	output logic rd_strobe
);
	import pllc_pkg::*;
	// bus idle from time zero
	initial
	begin
		addr = 5'h00;
		wdata = 32'h00000000;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
	end
	// one write; callers keep counter, modulus, numerator and band divider legal
	task automatic write_reg(input logic [2:0] idx, input logic [31:0] d);
		@(posedge clk);
		addr <= {idx, 2'b00};
		wdata <= d;
		wr_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
	endtask
	// one read; data taken in the cycle after the strobe
	task automatic read_reg(input logic [2:0] idx, output logic [31:0] d);
		@(posedge clk);
		addr <= {idx, 2'b00};
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		#1;
		d = rdata;
	endtask
endmodule

// ### sim/pll_synth_digital_control_test.sv
// pll_synth_digital_control_test: scenario bench for the synthesizer control block.
// assumes the host model on the register port and a slow phase-detector clock from here.
`timescale 1ns/1ps
module pll_synth_digital_control_test;
	import pllc_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] addr;
	logic [31:0] wdata, rdata, d;
	logic wr_strobe, rd_strobe, frac_mode, n_counter_hold, pump_hiz, test_out_pin, test_out_oe;
	logic lock_indicator, lock_indicator_oe, fastlock_ground_pin, fastlock_ground_oe;
	logic autoselect_busy, out_a_enable, out_b_enable, phase_step;
	logic pfd_clk_in = 1'b0, analog_lock = 1'b0, outputs_gate_pin = 1'b1;
	logic readback_load = 1'b0, readback_shift = 1'b0;
	logic [4:0] pfd_skew_ns = 5'h00;
	logic [2:0] tune_adc = 3'h0;
	logic [15:0] n_value;
	logic [11:0] frac_value, mod_value, phase_offset;
	logic [4:0] fb_extra_div;
	logic [2:0] out_a_ratio, out_b_ratio;
	logic [3:0] pump_current_code;
	logic [5:0] vco_sel;
	int n_fail = 0;
	int checked = 0;
	pllc_ctrl i_dut (.clk, .resetn, .addr, .wdata, .wr_strobe, .rd_strobe, .rdata,
		.pfd_clk_in, .pfd_skew_ns, .tune_adc, .analog_lock, .outputs_gate_pin,
		.readback_load, .readback_shift, .n_value, .frac_value, .mod_value, .frac_mode,
		.fb_extra_div, .n_counter_hold, .out_a_ratio, .out_b_ratio, .pump_hiz,
		.pump_current_code, .test_out_pin, .test_out_oe, .lock_indicator, .lock_indicator_oe,
		.fastlock_ground_pin, .fastlock_ground_oe, .vco_sel, .autoselect_busy,
		.out_a_enable, .out_b_enable, .phase_offset, .phase_step);
	pllc_host_model i_host (.clk, .rdata, .addr, .wdata, .wr_strobe, .rd_strobe);
	// 20 MHz clock
	always #25 clk = ~clk;
	// value compare
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// write, then let derived outputs land
	task automatic wr(input logic [2:0] i, input logic [31:0] v);
		i_host.write_reg(i, v);
		cyc(2);
	endtask
	// n phase-detector cycles, three clocks high and three low
	task automatic pfd(input int n);
		repeat (n)
		begin
			@(posedge clk);
			pfd_clk_in <= 1'b1;
			repeat (3) @(posedge clk);
			pfd_clk_in <= 1'b0;
			repeat (2) @(posedge clk);
		end
		cyc(4);
	endtask
	task automatic t_reset();
		i_host.read_reg(3'h0, d);
		chk("r0", PLLC_R0_RST, d);
		i_host.read_reg(3'h1, d);
		chk("r1", PLLC_R1_RST, d);
		i_host.read_reg(3'h2, d);
		chk("r2", PLLC_R2_RST, d);
		i_host.read_reg(3'h7, d);
		chk("unmapped", 32'h0, d);
	endtask
	task automatic t_outputs();
		for (int r = 0; r < 8; r++)
		begin
			wr(3'h4, (32'(r) << PLLC_OUTA_RATIO_LSB) | 32'h00000120);
			chk("out_a_ratio", r, out_a_ratio);
			chk("fb_extra_div", (r > 4) ? 32'h10 : 32'h1 << r, fb_extra_div);
			chk("out_b_ratio", r, out_b_ratio);
		end
		wr(3'h4, 32'h00b00320);
		chk("fb_extra_div", 32'h1, fb_extra_div);
		chk("out_b_ratio", 32'h0, out_b_ratio);
		chk("out_a_enable", 32'h1, out_a_enable);
		@(posedge clk);
		outputs_gate_pin <= 1'b0;
		cyc(5);
		chk("gated_a", 32'h0, out_a_enable);
		chk("gated_b", 32'h0, out_b_enable);
		outputs_gate_pin <= 1'b1;
		wr(3'h4, 32'h00000100);
		cyc(3);
		chk("only_a", 32'h0, out_a_enable);
		chk("only_b", 32'h1, out_b_enable);
	endtask
	task automatic t_mode();
		wr(3'h3, 32'h02000000);
		wr(3'h1, 32'h00018020);
		wr(3'h0, 32'h80320000);
		chk("int_mode", 32'h0, frac_mode);
		chk("n_value", 32'h64, n_value);
		chk("mod_value", 32'h4, mod_value);
		chk("vas_off", 32'h0, autoselect_busy);
		wr(3'h0, 32'h00320028);
		chk("frac_mode", 32'h1, frac_mode);
		chk("frac_value", 32'h5, frac_value);
		wr(3'h0, 32'h00320000);
		chk("zero_stay", 32'h1, frac_mode);
		wr(3'h5, 32'h01000000);
		wr(3'h0, 32'h00320000);
		chk("zero_auto", 32'h0, frac_mode);
		wr(3'h2, 32'h04000018);
		chk("n_hold", 32'h1, n_counter_hold);
		chk("pump_hiz", 32'h1, pump_hiz);
		chk("test_high", 32'h3, {test_out_oe, test_out_pin});
		wr(3'h2, 32'h08000000);
		chk("n_run", 32'h0, n_counter_hold);
		chk("pump_on", 32'h0, pump_hiz);
		chk("test_low", 32'h2, {test_out_oe, test_out_pin});
	endtask
	task automatic t_lock();
		wr(3'h5, 32'h01400000);
		wr(3'h2, 32'h18000100);
		pfd(4);
		chk("int_lock_4", 32'h0, lock_indicator);
		pfd(1);
		chk("int_lock_5", 32'h1, lock_indicator);
		chk("test_dlock", 32'h3, {test_out_oe, test_out_pin});
		pfd_skew_ns <= 5'h10;
		pfd(1);
		chk("int_unlock", 32'h0, lock_indicator);
		wr(3'h2, 32'h80000100);
		pfd_skew_ns <= 5'h05;
		pfd(6);
		chk("fast_window", 32'h0, lock_indicator);
		wr(3'h2, 32'h00000000);
		pfd_skew_ns <= 5'h09;
		pfd(39);
		chk("frac_lock_39", 32'h0, lock_indicator);
		pfd(1);
		chk("frac_lock_40", 32'h1, lock_indicator);
		pfd_skew_ns <= 5'h0f;
		pfd(1);
		chk("frac_hold", 32'h1, lock_indicator);
		pfd_skew_ns <= 5'h10;
		pfd(1);
		chk("frac_unlock", 32'h0, lock_indicator);
		wr(3'h5, 32'h01800000);
		cyc(4);
		chk("ana_low", 32'h1, lock_indicator_oe);
		analog_lock <= 1'b1;
		cyc(5);
		chk("ana_free", 32'h0, lock_indicator_oe);
	endtask
	task automatic t_vas();
		wr(3'h4, 32'h00001120);
		wr(3'h3, 32'h00008008);
		wr(3'h0, 32'h80320000);
		chk("vas_start", 32'h1, autoselect_busy);
		pfd(9);
		chk("vas_run", 32'h1, autoselect_busy);
		pfd(1);
		chk("vas_done", 32'h0, autoselect_busy);
		chk("fl_pump", 32'hf, pump_current_code);
		chk("fl_ground", 32'h1, fastlock_ground_oe & ~fastlock_ground_pin);
		pfd(3);
		chk("fl_hold", 32'h1, fastlock_ground_oe);
		pfd(1);
		chk("fl_end", 32'h0, fastlock_ground_oe);
		chk("pump_back", 32'h0, pump_current_code);
	endtask
	task automatic t_retune();
		wr(3'h3, 32'haa000000);
		chk("manual_vco", 32'h2a, vco_sel);
		tune_adc <= 3'h5;
		cyc(4);
		i_host.read_reg(3'h6, d);
		chk("adc_read", 32'h5, d[22:20]);
		wr(3'h3, 32'h28000000);
		tune_adc <= 3'h7;
		cyc(6);
		chk("no_retune", 32'h0, autoselect_busy);
		wr(3'h3, 32'h29000000);
		cyc(4);
		chk("retune", 32'h1, autoselect_busy);
		tune_adc <= 3'h2;
		pfd(12);
		chk("retune_done", 32'h0, autoselect_busy);
	endtask
	task automatic t_phase();
		wr(3'h5, 32'h01440000);
		wr(3'h2, 32'h10000100);
		pfd_skew_ns <= 5'h00;
		pfd(5);
		chk("locked", 32'h1, lock_indicator);
		i_host.write_reg(3'h3, 32'h28010000);
		cyc(0);
		chk("step_pulse", 32'h1, phase_step);
		chk("phase_1", 32'h3, phase_offset);
		cyc(1);
		chk("step_end", 32'h0, phase_step);
		wr(3'h3, 32'h28000000);
		wr(3'h3, 32'h28010000);
		chk("phase_2", 32'h2, phase_offset);
		readback_load <= 1'b1;
		@(posedge clk);
		readback_load <= 1'b0;
		cyc(2);
		chk("rb_msb", 32'h3, {test_out_oe, test_out_pin});
		readback_shift <= 1'b1;
		@(posedge clk);
		readback_shift <= 1'b0;
		cyc(2);
		chk("rb_next", 32'h2, {test_out_oe, test_out_pin});
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		cyc(2);
		t_reset();
		t_outputs();
		t_mode();
		t_lock();
		t_vas();
		t_retune();
		t_phase();
		give_verdict();
	end
	// watchdog, about ten thousand cycles
	initial
	begin
		#500000;
		n_fail++;
		give_verdict();
	end
endmodule
